// >>> src/phase_mode_defines.svh
// Offsets, field positions, reset values and timing counts of the selector
`ifndef PHASE_MODE_DEFINES_SVH
`define PHASE_MODE_DEFINES_SVH

`define CLK_FREQ_HZ 50000000
`define VID_WIDTH 7
// Masking interval in microseconds; also the VID transient period
`define PG_MASK_US 130
// Scaled per microsecond first so the product stays inside 32 bits
`define PG_MASK_CYCLES (`PG_MASK_US * (`CLK_FREQ_HZ / 1000000))
// VID deskew time in nanoseconds, least time so rounded up
`define VID_SETTLE_NS 400
`define VID_SETTLE_CYCLES ((`VID_SETTLE_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
// Register byte offsets
`define REG_CONTROL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_VID 32'h0000_0008
`define REG_CLOCK 32'h0000_000C
// Control register fields
`define CTL_ENABLE_BIT 0
`define CTL_POWER_STATE_N_BIT 1
`define CTL_DEEPER_SLEEP_BIT 2
`define CTL_CURRENT_LIMIT_BIT 3
`define CTL_RESET 32'h0000_0002
// Clock register: base master clock period and per-step slowdown
`define CLK_BASE_RESET 16'h0032
`define CLK_SLOPE_RESET 8'h01
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> src/phase_mode_pkg.sv
// Types shared by the phase and mode selector
package phase_mode_pkg;
  typedef enum logic [1:0] {
    CFG_ONE = 2'b00,
    CFG_GRAPHICS = 2'b01,
    CFG_TWO = 2'b10,
    CFG_THREE = 2'b11
  } phase_cfg_type;

  typedef enum logic [1:0] {
    MODE_PWM_N = 2'b00,
    MODE_RIPPLE_CCM = 2'b01,
    MODE_RIPPLE_AUTO = 2'b11,
    MODE_PWM_ONE = 2'b10
  } ctrl_mode_type;

  typedef enum logic [1:0] {
    RIP_IDLE = 2'b00,
    RIP_HIGH = 2'b01,
    RIP_LOW = 2'b11
  } ripple_state_type;
endpackage

// >>> src/pwm_phase_clock.sv
// Master clock divider and interleaved per-phase PWM pulses
`timescale 1ns/10ps
`include "phase_mode_defines.svh"

module pwm_phase_clock (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] master_period,
  input wire logic [1:0] phases_used,
  input wire logic [15:0] on_time,
  output logic cycle_start,
  output logic [2:0] pwm_out
);
  logic [15:0] tick_count;
  logic [1:0] phase_index;
  logic [15:0] on_count [3];

  // Master clock: one tick per period, shared round robin by phases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_count <= 16'h0000;
      phase_index <= 2'h0;
      cycle_start <= 1'b0;
    end else if (tick_count + 16'h0001 >= master_period) begin
      tick_count <= 16'h0000;
      cycle_start <= (phase_index + 2'h1 >= phases_used);
      if (phase_index + 2'h1 >= phases_used) begin
        phase_index <= 2'h0;
      end else begin
        phase_index <= phase_index + 2'h1;
      end
    end else begin
      tick_count <= tick_count + 16'h0001;
      cycle_start <= 1'b0;
    end
  end

  // Each phase timed on its own so pulses may overlap near full duty
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_phase
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          on_count[g] <= 16'h0000;
          pwm_out[g] <= 1'b0;
        end else if (tick_count == 16'h0000 && phase_index == 2'(g) &&
                     2'(g) < phases_used) begin
          on_count[g] <= on_time;
          pwm_out[g] <= (on_time != 16'h0000);
        end else if (on_count[g] > 16'h0001) begin
          on_count[g] <= on_count[g] - 16'h0001;
        end else begin
          on_count[g] <= 16'h0000;
          pwm_out[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// >>> src/buck_phase_mode_selector.sv
// Phase count and control mode selection with AXI4-Lite registers
`timescale 1ns/10ps
`include "phase_mode_defines.svh"

module buck_phase_mode_selector (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phase_strap_lo,
  input wire logic phase_strap_hi,
  input wire logic [6:0] voltage_id_code,
  input wire logic comp_above_ripple,
  input wire logic ramp_reached_comp,
  input wire logic inductor_current_zero,
  output logic [2:0] high_side_drive,
  output logic low_side_drive_one,
  output logic high_side_drive_one,
  output logic power_good_mask,
  output logic boot_voltage_enable,
  output phase_mode_pkg::ctrl_mode_type mode,
  output logic [1:0] phases_active
);
  import phase_mode_pkg::*;

  localparam int MASK_CYCLES = `PG_MASK_CYCLES;
  localparam int SETTLE_CYCLES = `VID_SETTLE_CYCLES;

  logic [31:0] control;
  logic [15:0] clk_base;
  logic [7:0] clk_slope;
  phase_cfg_type cfg;
  logic cfg_taken;
  logic [1:0] cfg_phases;
  logic [6:0] vid_seen;
  logic [6:0] vid_applied;
  logic [4:0] settle_count;
  logic [12:0] mask_count;
  logic transient;
  ctrl_mode_type next_mode;
  logic [1:0] next_phases;
  logic [15:0] master_period;
  logic [15:0] on_time;
  logic cycle_start;
  logic [2:0] pwm_out;
  ripple_state_type ripple_state;
  logic ripple_mode;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire logic power_state_n = control[`CTL_POWER_STATE_N_BIT];
  wire logic deeper_sleep_in = control[`CTL_DEEPER_SLEEP_BIT];
  wire logic current_limit = control[`CTL_CURRENT_LIMIT_BIT];

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [3:0] strb);
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // Straps are wired, so sampled once after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= CFG_ONE;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      cfg <= phase_cfg_type'({phase_strap_hi, phase_strap_lo});
      cfg_taken <= 1'b1;
    end
  end

  always_comb begin
    case (cfg)
      CFG_TWO: cfg_phases = 2'd2;
      CFG_THREE: cfg_phases = 2'd3;
      default: cfg_phases = 2'd1;
    endcase
  end

  // Graphics mode starts straight to the VID level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_voltage_enable <= 1'b0;
    end else begin
      boot_voltage_enable <= cfg_taken && cfg != CFG_GRAPHICS;
    end
  end

  // VID skew filter: a new code must hold before it counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vid_seen <= 7'h00;
      vid_applied <= 7'h00;
      settle_count <= 5'h00;
    end else if (voltage_id_code != vid_seen) begin
      vid_seen <= voltage_id_code;
      settle_count <= 5'h00;
    end else if (settle_count < 5'(SETTLE_CYCLES)) begin
      settle_count <= settle_count + 5'h01;
    end else begin
      vid_applied <= vid_seen;
    end
  end

  // Transient period retriggered by each code change and sleep change
  logic sleep_last;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_count <= 13'h0000;
      sleep_last <= 1'b0;
    end else begin
      sleep_last <= deeper_sleep_in;
      if ((settle_count == 5'(SETTLE_CYCLES) && vid_applied != vid_seen) ||
          sleep_last != deeper_sleep_in) begin
        mask_count <= 13'(MASK_CYCLES);
      end else if (mask_count != 13'h0000) begin
        mask_count <= mask_count - 13'h0001;
      end
    end
  end

  assign transient = (mask_count != 13'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_good_mask <= 1'b0;
    end else begin
      power_good_mask <= transient;
    end
  end

  // Mode decision follows the priority of the mode table
  always_comb begin
    if (transient || (power_state_n && !deeper_sleep_in)) begin
      next_mode = MODE_PWM_N;
      next_phases = cfg_phases;
    end else if (!deeper_sleep_in) begin
      next_mode = current_limit ? MODE_PWM_N : MODE_RIPPLE_CCM;
      next_phases = current_limit ? cfg_phases : 2'd1;
    end else begin
      next_mode = current_limit ? MODE_PWM_ONE : MODE_RIPPLE_AUTO;
      next_phases = 2'd1;
    end
  end

  // Changes wait for the end of a switching cycle or for the ripple state to be RIP_IDLE
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_PWM_N;
      phases_active <= 2'd1;
    end else if ((ripple_mode && ripple_state == RIP_IDLE) ||
                 (!ripple_mode && cycle_start)) begin
      mode <= next_mode;
      phases_active <= next_phases;
    end
  end

  assign ripple_mode = (mode == MODE_RIPPLE_CCM || mode == MODE_RIPPLE_AUTO);

  // Lower VID gives a longer master clock period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_period <= `CLK_BASE_RESET;
    end else begin
      master_period <= clk_base +
        16'((7'h7F - vid_applied) * clk_slope);
    end
  end

  assign on_time = {1'b0, master_period[15:1]};

  pwm_phase_clock u_clock (
    .aclk(aclk),
    .aresetn(aresetn),
    .master_period(master_period),
    .phases_used(phases_active),
    .on_time(on_time),
    .cycle_start(cycle_start),
    .pwm_out(pwm_out)
  );

  // Ripple pulse on phase one: set on threshold, reset on ramp meet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ripple_state <= RIP_IDLE;
    end else if (!ripple_mode) begin
      ripple_state <= RIP_IDLE;
    end else begin
      case (ripple_state)
        RIP_IDLE: begin
          if (comp_above_ripple) begin
            ripple_state <= RIP_HIGH;
          end
        end
        RIP_HIGH: begin
          if (ramp_reached_comp) begin
            ripple_state <= RIP_LOW;
          end
        end
        default: begin
          if (comp_above_ripple) begin
            ripple_state <= RIP_HIGH;
          end else if (mode == MODE_RIPPLE_AUTO && inductor_current_zero) begin
            ripple_state <= RIP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_side_drive <= 3'b000;
      high_side_drive_one <= 1'b0;
      low_side_drive_one <= 1'b0;
    end else if (ripple_mode) begin
      high_side_drive <= {2'b00, ripple_state == RIP_HIGH};
      high_side_drive_one <= (ripple_state == RIP_HIGH);
      low_side_drive_one <= (ripple_state == RIP_LOW) &&
        !(mode == MODE_RIPPLE_AUTO && inductor_current_zero);
    end else begin
      high_side_drive <= pwm_out;
      high_side_drive_one <= pwm_out[0];
      low_side_drive_one <= !pwm_out[0];
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      control <= `CTL_RESET;
      clk_base <= `CLK_BASE_RESET;
      clk_slope <= `CLK_SLOPE_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (aw_addr[11:0] == `REG_CONTROL) begin
          control <= merge_bytes(control, w_data, w_strb) & 32'h0000_000F;
        end else if (aw_addr[11:0] == `REG_CLOCK) begin
          {clk_slope, clk_base} <= 24'(merge_bytes({8'h00, clk_slope,
                                        clk_base}, w_data, w_strb));
        end else if (aw_addr[11:0] != `REG_STATUS &&
                     aw_addr[11:0] != `REG_VID) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Read channel: one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      if (s_axi_araddr[11:0] == `REG_CONTROL) begin
        s_axi_rdata <= control;
      end else if (s_axi_araddr[11:0] == `REG_STATUS) begin
        s_axi_rdata <= {20'h00000, ripple_state, transient, cfg_taken,
                        cfg, phases_active, mode, 2'b00};
      end else if (s_axi_araddr[11:0] == `REG_VID) begin
        s_axi_rdata <= {9'h000, vid_applied, master_period};
      end else if (s_axi_araddr[11:0] == `REG_CLOCK) begin
        s_axi_rdata <= {8'h00, clk_slope, clk_base};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
endmodule

// >>> verification/buck_phase_mode_selector_checker.sv
// Port assertions for the phase and mode selector
`timescale 1ns/10ps
`include "phase_mode_defines.svh"

module buck_phase_mode_selector_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] voltage_id_code,
  input wire logic comp_above_ripple,
  input wire logic ramp_reached_comp,
  input wire logic inductor_current_zero,
  input wire logic [2:0] high_side_drive,
  input wire logic low_side_drive_one,
  input wire logic high_side_drive_one,
  input wire logic power_good_mask,
  input wire logic boot_voltage_enable,
  input wire phase_mode_pkg::ctrl_mode_type mode,
  input wire logic [1:0] phases_active
);
  import phase_mode_pkg::*;
  logic [15:0] mask_count;
  logic ripple;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign ripple = mode == MODE_RIPPLE_CCM || mode == MODE_RIPPLE_AUTO;
  // Saturates so a long retriggered mask cannot wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_good_mask) begin
      mask_count <= 16'h0000;
    end else if (mask_count != 16'hFFFF) begin
      mask_count <= mask_count + 16'h0001;
    end
  end
  sequence drive_up;
    ##[1:3] high_side_drive_one;
  endsequence
  sequence drive_down;
    ##[1:2] !high_side_drive_one;
  endsequence
  a_drive_one_copy: assert property (
    high_side_drive_one == high_side_drive[0])
    else $error("phase one drive differs from drive bus");
  a_phase_range: assert property (
    phases_active inside {2'h1, 2'h2, 2'h3})
    else $error("phase count out of range");
  a_graphics_single: assert property (
    $past(aresetn) && !boot_voltage_enable |-> phases_active == 2'h1)
    else $error("graphics config runs more than one phase");
  a_single_modes: assert property (
    mode != MODE_PWM_N |-> phases_active == 2'h1)
    else $error("single phase mode with several phases");
  a_transient_pwm: assert property (
    $rose(power_good_mask) |-> ##[0:400] mode == MODE_PWM_N)
    else $error("transient did not force multi phase pwm");
  a_mask_length: assert property (
    $fell(power_good_mask) |-> mask_count >= `PG_MASK_CYCLES)
    else $error("transient period too short");
  a_vid_masks: assert property (
    $past(aresetn) && $changed(voltage_id_code) |-> ##[1:40] power_good_mask)
    else $error("code change did not start a transient");
  a_ripple_start: assert property (
    ripple && $rose(comp_above_ripple) |-> drive_up)
    else $error("threshold crossing did not raise drive");
  a_ripple_end: assert property (
    ripple && high_side_drive_one && ramp_reached_comp && !comp_above_ripple
    |-> drive_down)
    else $error("ramp crossing did not drop drive");
  a_zero_current: assert property (
    mode == MODE_RIPPLE_AUTO && inductor_current_zero
    |-> ##[1:2] !low_side_drive_one)
    else $error("low side still on at zero current");
endmodule

bind buck_phase_mode_selector buck_phase_mode_selector_checker u_chk (
  .aclk, .aresetn, .voltage_id_code, .comp_above_ripple, .ramp_reached_comp,
  .inductor_current_zero, .high_side_drive, .low_side_drive_one,
  .high_side_drive_one, .power_good_mask, .boot_voltage_enable, .mode,
  .phases_active);

// >>> verification/cpu_vid_model.sv
// Processor side model stepping the voltage identification code
`timescale 1ns/10ps

module cpu_vid_model (
  input wire logic aclk,
  output logic [6:0] voltage_id_code
);
  initial voltage_id_code = 7'h40;
  // One LSB step at a time, spaced beyond the deskew filter
  task automatic move_to(input logic [6:0] target);
    logic [6:0] cur;
    cur = voltage_id_code;
    while (cur != target) begin
      repeat (30) @(posedge aclk);
      cur = cur < target ? cur + 7'h01 : cur - 7'h01;
      voltage_id_code <= cur;
    end
  endtask
endmodule

// >>> verification/buck_phase_mode_selector_test.sv
// Self-checking bench for the phase and mode selector
`timescale 1ns/10ps
`include "phase_mode_defines.svh"

module buck_phase_mode_selector_test;
  import phase_mode_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, phases_active, r, c;
  logic phase_strap_lo, phase_strap_hi, comp_above_ripple, ramp_reached_comp;
  logic inductor_current_zero, low_side_drive_one, high_side_drive_one;
  logic power_good_mask, boot_voltage_enable;
  logic [6:0] voltage_id_code;
  logic [2:0] high_side_drive;
  ctrl_mode_type mode;
  int err_total, checks;
  logic [1:0] ph_of [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  logic [1:0] cfgs [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  logic [3:0] ctl_v [6] = '{4'h2, 4'h0, 4'h8, 4'h6, 4'hE, 4'h2};
  logic [1:0] p_v [6] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h1, 2'h3};
  ctrl_mode_type m_v [6] = '{MODE_PWM_N, MODE_RIPPLE_CCM, MODE_PWM_N,
    MODE_RIPPLE_AUTO, MODE_PWM_ONE, MODE_PWM_N};

  buck_phase_mode_selector u_buck_phase_mode_selector (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .phase_strap_lo, .phase_strap_hi, .voltage_id_code, .comp_above_ripple,
    .ramp_reached_comp, .inductor_current_zero, .high_side_drive,
    .low_side_drive_one, .high_side_drive_one, .power_good_mask,
    .boot_voltage_enable, .mode, .phases_active);
  cpu_vid_model u_cpu_vid_model (.aclk, .voltage_id_code);

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  task automatic check(input string s, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Samples ready at the falling edge so the take edge is known in advance
  task automatic bus(input logic w, input logic [31:0] a, d);
    logic at, wt, ar, done;
    int n;
    done = 1'h0;
    n = 0;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    while (!done && n < 100) begin
      @(negedge aclk);
      n++;
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      done = w ? s_axi_bvalid === 1'h1 : s_axi_rvalid === 1'h1;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 1'h0;
      if (wt) s_axi_wvalid <= 1'h0;
      if (ar) s_axi_arvalid <= 1'h0;
      if (done) begin
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
      end
    end
    if (!done) check("bus answer", 32'h0, 32'h1);
  endtask

  // Lets any transient period run out
  task automatic settle;
    int n;
    n = 0;
    repeat (40) @(negedge aclk);
    while (power_good_mask !== 1'h0 && n < 8000) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic expect_mode(input ctrl_mode_type m, input logic [1:0] p);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (mode !== m && n < 2000);
    check("mode", 32'(mode), 32'(m));
    check("phases", 32'(phases_active), 32'(p));
  endtask

  task automatic pins(input logic above, ramp, zero);
    @(posedge aclk);
    comp_above_ripple <= above;
    ramp_reached_comp <= ramp;
    inductor_current_zero <= zero;
    repeat (4) @(negedge aclk);
  endtask

  function automatic logic [31:0] vid_word(input logic [6:0] v);
    return {9'h000, v, 16'h0040 + 16'(7'h7F - v) * 16'h0002};
  endfunction

  initial begin
    repeat (90000) @(posedge aclk);
    err_total++;
    complete_run;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {phase_strap_lo, phase_strap_hi} = 2'h0;
    {comp_above_ripple, ramp_reached_comp, inductor_current_zero} = 3'h0;
    err_total = 0;
    checks = 0;
    for (int i = 0; i < 4; i++) begin
      c = cfgs[i];
      @(posedge aclk);
      aresetn <= 1'h0;
      phase_strap_lo <= c[0];
      phase_strap_hi <= c[1];
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      settle();
      bus(1'h0, `REG_STATUS, 32'h0);
      check("status", q & 32'h3FF, {22'h0, 2'h1, c, ph_of[c], 4'h0});
      check("boot", 32'(boot_voltage_enable), 32'(c != 2'h1));
      $display("test straps %0d done", c);
    end
    bus(1'h0, `REG_CONTROL, 32'h0);
    check("control", q, `CTL_RESET);
    bus(1'h0, 32'h10, 32'h0);
    check("unmapped read", {q[31:2], r}, {30'h0, `RESP_SLVERR});
    bus(1'h1, 32'h10, 32'h5);
    check("unmapped write", 32'(r), 32'(`RESP_SLVERR));
    bus(1'h0, `REG_CLOCK, 32'h0);
    check("clock", q, {8'h00, `CLK_SLOPE_RESET, `CLK_BASE_RESET});
    bus(1'h1, `REG_CLOCK, 32'h0002_0040);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      bus(1'h1, `REG_CONTROL, {28'h0, ctl_v[i]});
      settle();
      expect_mode(m_v[i], p_v[i]);
    end
    // Three phases in PWM: every phase drive must pulse within a rotation
    q = 32'h0;
    repeat (600) begin
      @(negedge aclk);
      q = q | 32'(high_side_drive);
    end
    check("phase drives", q, 32'h7);
    $display("test mode table done");
    bus(1'h1, `REG_CONTROL, 32'h6);
    settle();
    expect_mode(MODE_RIPPLE_AUTO, 2'h1);
    pins(1'h1, 1'h0, 1'h0);
    check("drive up", 32'(high_side_drive_one), 32'h1);
    pins(1'h0, 1'h1, 1'h0);
    check("drive down", 32'(high_side_drive_one), 32'h0);
    check("low side on", 32'(low_side_drive_one), 32'h1);
    pins(1'h0, 1'h0, 1'h1);
    check("low side off", 32'(low_side_drive_one), 32'h0);
    pins(1'h0, 1'h0, 1'h0);
    $display("test ripple done");
    bus(1'h1, `REG_CONTROL, 32'h0);
    settle();
    expect_mode(MODE_RIPPLE_CCM, 2'h1);
    u_cpu_vid_model.move_to(7'h42);
    repeat (25) @(negedge aclk);
    check("mask", 32'(power_good_mask), 32'h1);
    expect_mode(MODE_PWM_N, 2'h3);
    settle();
    bus(1'h0, `REG_VID, 32'h0);
    check("vid", q & 32'h007F_FFFF, vid_word(7'h42));
    expect_mode(MODE_RIPPLE_CCM, 2'h1);
    u_cpu_vid_model.move_to(7'h3E);
    settle();
    bus(1'h0, `REG_VID, 32'h0);
    check("vid lower", q & 32'h007F_FFFF, vid_word(7'h3E));
    $display("test vid done");
    complete_run;
  end
endmodule
